// *** core/ptc_pkg.sv ***
// shared constants and carrier types of the prescaled timer/counter
package ptc_pkg;

   // ********************************
   // register map (byte addresses)
   // ********************************
   localparam int             PTC_ADDR_W            = 16;
   localparam int             PTC_DATA_W            = 8;
   localparam logic [15:0]    PTC_OFS_CONTROL       = 16'hfe10;
   localparam logic [15:0]    PTC_OFS_PRESCALE      = 16'hfe11;
   localparam logic [15:0]    PTC_OFS_LOW_COUNT     = 16'hfe12;
   localparam logic [15:0]    PTC_OFS_HIGH_COUNT    = 16'hfe13;
   localparam logic [15:0]    PTC_OFS_LOW_MATCH     = 16'hfe14;
   localparam logic [15:0]    PTC_OFS_HIGH_MATCH    = 16'hfe15;
   localparam logic [15:0]    PTC_OFS_LOW_CAPTURE   = 16'hfe16;
   localparam logic [15:0]    PTC_OFS_HIGH_CAPTURE  = 16'hfe17;

   // ********************************
   // control register fields
   // ********************************
   localparam int             PTC_BIT_HIGH_RUN      = 7;
   localparam int             PTC_BIT_LOW_RUN       = 6;
   localparam int             PTC_BIT_LENGTH        = 5;
   localparam int             PTC_BIT_EXT_CLOCK     = 4;
   localparam int             PTC_BIT_HIGH_FLAG     = 3;
   localparam int             PTC_BIT_HIGH_IE       = 2;
   localparam int             PTC_BIT_LOW_FLAG      = 1;
   localparam int             PTC_BIT_LOW_IE        = 0;

   // ********************************
   // reset value and counting constants
   // ********************************
   localparam logic [7:0]     PTC_RST_BYTE          = 8'h00;
   localparam logic [7:0]     PTC_ALL_ONES          = 8'hff;
   localparam logic [7:0]     PTC_ONE               = 8'h01;

   // ********************************
   // carrier types
   // ********************************
   typedef enum logic [1:0] {
      PTC_MODE_DUAL_TIMER,
      PTC_MODE_TIMER_EVENT,
      PTC_MODE_WIDE_TIMER,
      PTC_MODE_WIDE_EVENT
   } ptc_mode_type;

   typedef struct packed {
      logic                   low_capture_pin;
      logic                   high_capture_pin;
      logic                   event_low_pin;
      logic                   event_high_pin;
   } ptc_det_type;

   typedef struct packed {
      logic [15:0]            addr;
      logic [7:0]             wdata;
      logic                   wr;
      logic                   rd;
   } ptc_bus_type;

endpackage : ptc_pkg

// *** core/ptc_timer.sv ***
// prescaled 16-bit timer/counter with match buffers and capture registers
`timescale 1ns/1ps

module ptc_timer (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // power state
   input  wire logic                  hold_standby,
   // detection pulses from edge-detect logic
   input  wire ptc_pkg::ptc_det_type  det,
   // register port
   input  wire ptc_pkg::ptc_bus_type  bus,
   output logic [7:0]                 rdata_reg,
   // interrupt requests
   output logic                       low_irq_reg,
   output logic                       high_irq_reg
);
   import ptc_pkg::*;

   // ********************************
   // reset release
   // ********************************
   logic              rst_meta_reg;
   logic              rst_sync_reg;
   logic              rst_sync_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_sync_n = rst_sync_reg;

   // ********************************
   // state and decode
   // ********************************
   logic [7:0]        control_reg;
   logic [7:0]        prescaler_match_value_reg;
   logic [7:0]        prescale_count_reg;
   logic [7:0]        low_counter_reg;
   logic [7:0]        high_counter_reg;
   logic [7:0]        low_match_data_reg;
   logic [7:0]        high_match_data_reg;
   logic [7:0]        low_buffer_reg;
   logic [7:0]        high_buffer_reg;
   logic [7:0]        low_capture_reg;
   logic [7:0]        high_capture_reg;
   logic              wr_control;
   logic              wr_prescale;
   logic              wr_low_match;
   logic              wr_high_match;
   logic              low_run;
   logic              high_run;
   logic              length_select;
   logic              external_clock_select;
   ptc_mode_type      mode;
   logic              prescale_match;
   logic              event_pulse;
   logic              low_tick;
   logic              high_tick;
   logic              wide_equal;
   logic              low_match;
   logic              high_match;
   logic              low_carry;
   logic              low_capture_hit;
   logic              high_capture_hit;
   logic [7:0]        control_next;

   assign wr_control            = bus.wr && (bus.addr == PTC_OFS_CONTROL);
   assign wr_prescale           = bus.wr && (bus.addr == PTC_OFS_PRESCALE);
   assign wr_low_match          = bus.wr && (bus.addr == PTC_OFS_LOW_MATCH);
   assign wr_high_match         = bus.wr && (bus.addr == PTC_OFS_HIGH_MATCH);
   assign low_run               = control_reg[PTC_BIT_LOW_RUN];
   assign high_run              = control_reg[PTC_BIT_HIGH_RUN];
   assign length_select         = control_reg[PTC_BIT_LENGTH];
   assign external_clock_select = control_reg[PTC_BIT_EXT_CLOCK];

   // ********************************
   // prescaler
   // ********************************
   // a write restarts the count, so no match is issued in that cycle
   assign prescale_match = !hold_standby && !wr_prescale
                           && (prescale_count_reg == prescaler_match_value_reg);

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prescale_count_reg <= PTC_RST_BYTE;
      end else if (wr_prescale || prescale_match) begin
         prescale_count_reg <= PTC_RST_BYTE;
      end else if (!hold_standby) begin
         prescale_count_reg <= prescale_count_reg + PTC_ONE;
      end
   end

   // ********************************
   // mode and count clocks
   // ********************************
   assign event_pulse = det.event_low_pin || det.event_high_pin;

   always_comb begin
      mode      = PTC_MODE_DUAL_TIMER;
      low_tick  = prescale_match;
      high_tick = prescale_match;
      case ({length_select, external_clock_select})
         2'b00: begin
            mode      = PTC_MODE_DUAL_TIMER;
            low_tick  = prescale_match;
            high_tick = prescale_match;
         end
         2'b01: begin
            mode      = PTC_MODE_TIMER_EVENT;
            low_tick  = event_pulse;
            high_tick = prescale_match;
         end
         2'b10: begin
            mode      = PTC_MODE_WIDE_TIMER;
            low_tick  = prescale_match;
            high_tick = prescale_match;
         end
         2'b11: begin
            mode      = PTC_MODE_WIDE_EVENT;
            low_tick  = event_pulse;
            high_tick = event_pulse;
         end
         default: begin
            mode      = PTC_MODE_DUAL_TIMER;
            low_tick  = prescale_match;
            high_tick = prescale_match;
         end
      endcase
   end

   // ********************************
   // match detection
   // ********************************
   assign wide_equal = ({high_counter_reg, low_counter_reg} == {high_buffer_reg, low_buffer_reg});
   assign low_carry  = (low_counter_reg == PTC_ALL_ONES);

   always_comb begin
      low_match  = 1'b0;
      high_match = 1'b0;
      case (mode)
         PTC_MODE_WIDE_TIMER, PTC_MODE_WIDE_EVENT: begin
            // both bytes must run together for a wide match
            low_match  = low_run && high_run && low_tick && wide_equal;
            high_match = low_match;
         end
         PTC_MODE_DUAL_TIMER, PTC_MODE_TIMER_EVENT: begin
            low_match  = low_run && low_tick && (low_counter_reg == low_buffer_reg);
            high_match = high_run && high_tick && (high_counter_reg == high_buffer_reg);
         end
         default: begin
            low_match  = 1'b0;
            high_match = 1'b0;
         end
      endcase
   end

   // ********************************
   // low counter
   // ********************************
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_counter_reg <= PTC_RST_BYTE;
      end else if (!low_run || low_match) begin
         low_counter_reg <= PTC_RST_BYTE;
      end else if (low_tick) begin
         low_counter_reg <= low_counter_reg + PTC_ONE;
      end
   end

   // ********************************
   // high counter
   // ********************************
   // in wide modes the high byte steps on the low byte's carry
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         high_counter_reg <= PTC_RST_BYTE;
      end else if (!high_run || high_match) begin
         high_counter_reg <= PTC_RST_BYTE;
      end else if (high_tick && (!length_select || low_carry)) begin
         high_counter_reg <= high_counter_reg + PTC_ONE;
      end
   end

   // ********************************
   // match data and buffers
   // ********************************
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prescaler_match_value_reg <= PTC_RST_BYTE;
         low_match_data_reg        <= PTC_RST_BYTE;
         high_match_data_reg       <= PTC_RST_BYTE;
      end else begin
         if (wr_prescale) begin
            prescaler_match_value_reg <= bus.wdata;
         end
         if (wr_low_match) begin
            low_match_data_reg <= bus.wdata;
         end
         if (wr_high_match) begin
            high_match_data_reg <= bus.wdata;
         end
      end
   end

   // buffers lag the data register by one cycle while stopped
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_buffer_reg  <= PTC_RST_BYTE;
         high_buffer_reg <= PTC_RST_BYTE;
      end else begin
         if (!low_run || low_match) begin
            low_buffer_reg <= low_match_data_reg;
         end
         if (!high_run || high_match) begin
            high_buffer_reg <= high_match_data_reg;
         end
      end
   end

   // ********************************
   // control register and flags
   // ********************************
   always_comb begin
      control_next = control_reg;
      if (wr_control) begin
         control_next = bus.wdata;
      end
      // a match in the clearing cycle still sets the flag
      if (low_match) begin
         control_next[PTC_BIT_LOW_FLAG] = 1'b1;
      end
      if (high_match) begin
         control_next[PTC_BIT_HIGH_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         control_reg <= PTC_RST_BYTE;
      end else begin
         control_reg <= control_next;
      end
   end

   // ********************************
   // interrupt requests
   // ********************************
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_irq_reg  <= 1'b0;
         high_irq_reg <= 1'b0;
      end else begin
         low_irq_reg  <= control_reg[PTC_BIT_LOW_FLAG] && control_reg[PTC_BIT_LOW_IE];
         high_irq_reg <= control_reg[PTC_BIT_HIGH_FLAG] && control_reg[PTC_BIT_HIGH_IE];
      end
   end

   // ********************************
   // capture
   // ********************************
   assign high_capture_hit = det.high_capture_pin || det.event_high_pin;
   assign low_capture_hit  = length_select ? high_capture_hit
                                           : (det.low_capture_pin || det.event_low_pin);

   // captures hold until the next qualifying pulse
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_capture_reg  <= PTC_RST_BYTE;
         high_capture_reg <= PTC_RST_BYTE;
      end else begin
         if (low_capture_hit) begin
            low_capture_reg <= low_counter_reg;
         end
         if (high_capture_hit) begin
            high_capture_reg <= high_counter_reg;
         end
      end
   end

   // ********************************
   // read port
   // ********************************
   // data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_reg <= PTC_RST_BYTE;
      end else if (bus.rd) begin
         case (bus.addr)
            PTC_OFS_CONTROL:      rdata_reg <= control_reg;
            PTC_OFS_PRESCALE:     rdata_reg <= prescaler_match_value_reg;
            PTC_OFS_LOW_COUNT:    rdata_reg <= low_counter_reg;
            PTC_OFS_HIGH_COUNT:   rdata_reg <= high_counter_reg;
            PTC_OFS_LOW_MATCH:    rdata_reg <= low_match_data_reg;
            PTC_OFS_HIGH_MATCH:   rdata_reg <= high_match_data_reg;
            PTC_OFS_LOW_CAPTURE:  rdata_reg <= low_capture_reg;
            PTC_OFS_HIGH_CAPTURE: rdata_reg <= high_capture_reg;
            default:              rdata_reg <= PTC_RST_BYTE;
         endcase
      end else begin
         rdata_reg <= PTC_RST_BYTE;
      end
   end

endmodule : ptc_timer

// *** tb/ptc_det_model.sv ***
// detection pulse source in place of the pin edge-detect logic
`timescale 1ns/1ps
module ptc_det_model (
   // clock and reset
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   // request from the bench
   input wire logic                  fire,
   input wire logic [3:0]            pattern,
   // detection pulses
   output     ptc_pkg::ptc_det_type  det
);
   import ptc_pkg::*;
   // edge detect never stretches a pulse past one cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         det <= '0;
      end else begin
         det <= fire ? ptc_det_type'(pattern) : '0;
      end
   end
endmodule : ptc_det_model

// *** tb/ptc_timer_sva.sv ***
// port-level assertion checker for the prescaled timer/counter
`timescale 1ns/1ps
module ptc_timer_sva (
   // clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rst_n,
   // watched inputs
   input wire logic                 hold_standby,
   input wire ptc_pkg::ptc_det_type det,
   input wire ptc_pkg::ptc_bus_type bus,
   // watched outputs
   input wire logic [7:0]           rdata_reg,
   input wire logic                 low_irq_reg,
   input wire logic                 high_irq_reg
);
   import ptc_pkg::*;
   // ********************************
   // shadow of software-written state
   // ********************************
   logic [7:0] ctl_reg, pre_reg, lmd_reg, hmd_reg;
   logic [1:0] loff_reg, hoff_reg;
   wire        ctl_wr = bus.wr && bus.addr == PTC_OFS_CONTROL;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= 8'h00;
         pre_reg <= 8'h00;
         lmd_reg <= 8'h00;
         hmd_reg <= 8'h00;
      end else if (bus.wr) begin
         if (bus.addr == PTC_OFS_CONTROL) ctl_reg <= bus.wdata;
         if (bus.addr == PTC_OFS_PRESCALE) pre_reg <= bus.wdata;
         if (bus.addr == PTC_OFS_LOW_MATCH) lmd_reg <= bus.wdata;
         if (bus.addr == PTC_OFS_HIGH_MATCH) hmd_reg <= bus.wdata;
      end
   end
   // cycles since stop, saturating; counters need a cycle to clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         loff_reg <= 2'h0;
         hoff_reg <= 2'h0;
      end else begin
         loff_reg <= ctl_reg[PTC_BIT_LOW_RUN] ? 2'h0 : (loff_reg == 2'h3 ? 2'h3 : loff_reg + 2'h1);
         hoff_reg <= ctl_reg[PTC_BIT_HIGH_RUN] ? 2'h0 : (hoff_reg == 2'h3 ? 2'h3 : hoff_reg + 2'h1);
      end
   end
   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_low_ie_off;
      ctl_wr && !bus.wdata[PTC_BIT_LOW_IE] ##1 !ctl_wr;
   endsequence
   sequence s_high_ie_off;
      ctl_wr && !bus.wdata[PTC_BIT_HIGH_IE] ##1 !ctl_wr;
   endsequence
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata_reg == 8'h00)
      else $error("read data without a read");
   a_unmapped_zero: assert property (bus.rd && (bus.addr < PTC_OFS_CONTROL || bus.addr > PTC_OFS_HIGH_CAPTURE)
      |=> rdata_reg == 8'h00) else $error("unmapped read not zero");
   a_prescale_readback: assert property (bus.rd && bus.addr == PTC_OFS_PRESCALE |=> rdata_reg == pre_reg)
      else $error("prescaler match readback wrong");
   a_low_data_readback: assert property (bus.rd && bus.addr == PTC_OFS_LOW_MATCH |=> rdata_reg == lmd_reg)
      else $error("low match data readback wrong");
   a_high_data_readback: assert property (bus.rd && bus.addr == PTC_OFS_HIGH_MATCH |=> rdata_reg == hmd_reg)
      else $error("high match data readback wrong");
   a_low_stop_zero: assert property (bus.rd && bus.addr == PTC_OFS_LOW_COUNT && loff_reg == 2'h3
      |=> rdata_reg == 8'h00) else $error("stopped low counter not zero");
   a_high_stop_zero: assert property (bus.rd && bus.addr == PTC_OFS_HIGH_COUNT && hoff_reg == 2'h3
      |=> rdata_reg == 8'h00) else $error("stopped high counter not zero");
   a_low_irq_off: assert property (s_low_ie_off |-> ##1 !low_irq_reg)
      else $error("low request with enable cleared");
   a_high_irq_off: assert property (s_high_ie_off |-> ##1 !high_irq_reg)
      else $error("high request with enable cleared");
   // the request is built from the enable one cycle earlier, so a write in the rise cycle must not count
   a_low_irq_cause: assert property ($rose(low_irq_reg) |-> $past(ctl_reg[PTC_BIT_LOW_IE]))
      else $error("low request rose while disabled");
   a_high_irq_cause: assert property ($rose(high_irq_reg) |-> $past(ctl_reg[PTC_BIT_HIGH_IE]))
      else $error("high request rose while disabled");
endmodule : ptc_timer_sva

// *** tb/ptc_timer_tb_top.sv ***
// self-checking bench for the prescaled timer/counter
`timescale 1ns/1ps
module ptc_timer_tb_top;
   import ptc_pkg::*;
   logic        sys_clk = 1'b0, rst_n = 1'b0, hold_standby = 1'b0, fire = 1'b0;
   logic [3:0]  pattern = 4'h0;
   ptc_bus_type bus = '0;
   ptc_det_type det;
   logic [7:0]  rdata_reg, p, l;
   logic        low_irq_reg, high_irq_reg;
   int          err_count = 0, compares = 0, seed = 46, cyc = 0;
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   ptc_timer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hold_standby(hold_standby), .det(det), .bus(bus),
      .rdata_reg(rdata_reg), .low_irq_reg(low_irq_reg), .high_irq_reg(high_irq_reg));
   ptc_det_model u_det (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire), .pattern(pattern), .det(det));
   // ********************************
   // tasks
   // ********************************
   // expected match interval in cycle clocks for a match value and a prescaler value
   function automatic int exp_period(input int m, input int pr);
      return (m + 1) * (pr + 1);
   endfunction : exp_period
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 chk({8'h00, rdata_reg}, {8'h00, e});
   endtask : rd
   task automatic pulse(input logic [3:0] pt);
      @(posedge sys_clk);
      fire <= 1'b1;
      pattern <= pt;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (3) @(posedge sys_clk);
      // settle past the edge before any look at the outputs
      #1;
   endtask : pulse
   task automatic wait_lvl(input bit hi, input bit v, output int t);
      int n;
      n = 0;
      #1;
      while (((hi ? high_irq_reg : low_irq_reg) !== v) && n < 3000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(16'(n < 3000), 16'h1);
      t = cyc;
   endtask : wait_lvl
   // spacing of two request rises, flags cleared in between
   task automatic period(input bit hi, input logic [7:0] c, input int exp);
      int t1, t2;
      wr(PTC_OFS_CONTROL, c);
      wait_lvl(hi, 1'b0, t1);
      wait_lvl(hi, 1'b1, t1);
      wr(PTC_OFS_CONTROL, c);
      wait_lvl(hi, 1'b0, t2);
      wait_lvl(hi, 1'b1, t2);
      chk(16'(t2 - t1), 16'(exp));
   endtask : period
   task automatic final_report();
      $display("err_count %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   // ********************************
   // scenarios
   // ********************************
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      for (int a = 16'hfe0f; a <= 16'hfe18; a++) rd(16'(a), 8'h00);
      repeat (4) begin
         p = 8'($random(seed));
         wr(PTC_OFS_PRESCALE, p);
         wr(PTC_OFS_LOW_MATCH, ~p);
         wr(PTC_OFS_HIGH_MATCH, p ^ 8'h5a);
         wr(PTC_OFS_LOW_COUNT, p);
         rd(PTC_OFS_PRESCALE, p);
         rd(PTC_OFS_LOW_MATCH, ~p);
         rd(PTC_OFS_HIGH_MATCH, p ^ 8'h5a);
         rd(PTC_OFS_LOW_COUNT, 8'h00);
      end
      p = 8'h02 + 8'($unsigned($random(seed)) % 4);
      l = 8'h02 + 8'($unsigned($random(seed)) % 4);
      wr(PTC_OFS_PRESCALE, p);
      wr(PTC_OFS_LOW_MATCH, l);
      wr(PTC_OFS_HIGH_MATCH, l + 8'h01);
      period(1'b0, 8'hc5, exp_period(l, p));
      period(1'b1, 8'hc5, exp_period(l + 1, p));
      // frozen prescaler gives no ticks, so no new flags
      @(posedge sys_clk);
      hold_standby <= 1'b1;
      wr(PTC_OFS_CONTROL, 8'hc5);
      repeat (60) @(posedge sys_clk);
      chk({15'h0, low_irq_reg | high_irq_reg}, 16'h0);
      hold_standby <= 1'b0;
      wr(PTC_OFS_CONTROL, 8'h00);
      wr(PTC_OFS_LOW_MATCH, 8'h02);
      wr(PTC_OFS_CONTROL, 8'h51);
      pulse(4'h2);
      pulse(4'h1);
      chk({15'h0, low_irq_reg}, 16'h0);
      pulse(4'h1);
      chk({15'h0, low_irq_reg}, 16'h1);
      repeat (2) pulse(4'h2);
      pulse(4'h8);
      rd(PTC_OFS_LOW_CAPTURE, 8'h02);
      wr(PTC_OFS_CONTROL, 8'h00);
      wr(PTC_OFS_LOW_MATCH, 8'hff);
      wr(PTC_OFS_HIGH_MATCH, 8'hff);
      wr(PTC_OFS_CONTROL, 8'hf0);
      repeat (259) pulse(4'h2);
      pulse(4'h8);
      rd(PTC_OFS_LOW_CAPTURE, 8'h02);
      pulse(4'h4);
      rd(PTC_OFS_LOW_CAPTURE, 8'h03);
      rd(PTC_OFS_HIGH_CAPTURE, 8'h01);
      wr(PTC_OFS_CONTROL, 8'h00);
      wr(PTC_OFS_PRESCALE, 8'h00);
      wr(PTC_OFS_LOW_MATCH, 8'h02);
      wr(PTC_OFS_HIGH_MATCH, 8'h01);
      period(1'b0, 8'he5, exp_period(16'h0102, 0));
      chk({15'h0, high_irq_reg}, 16'h1);
      final_report();
   end
   initial begin
      #800000;
      err_count++;
      final_report();
   end
endmodule : ptc_timer_tb_top
bind ptc_timer ptc_timer_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .hold_standby(hold_standby), .det(det),
   .bus(bus), .rdata_reg(rdata_reg), .low_irq_reg(low_irq_reg), .high_irq_reg(high_irq_reg));
